/* File: src/spi_status_flags.sv */
/*
  Status flag logic of the serial peripheral interface: the three flags of
  serial_port_status, a sticky event register with mask, and interrupt outputs.
  Assumes the shift engine and control register run on core_clk, and that the
  slave-select pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ns

// Behaviour
// - Transfer end sets done flag, bit 7
// - Interrupt vectoring clears the done flag
// - Writing zero clears done; resets zero
// - Data write while busy sets collision, bit 6
// - Zero write or idle data write clears collision
// - Master, detect enabled, select low sets fault
// - Writing zero clears the mode fault flag unless the select is still held low
module spi_status_flags (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire spi_status_pkg::bus_req_t busReq,
  input  wire spi_status_pkg::shift_ind_t shiftInd,
  input  wire logic                    vectorAck,
  input  wire logic                    slaveSelectPin_n,
  output logic [7:0]                   regRdata,
  output logic                         spiIrq,
  output logic                         intrOut
);

  // Address decode

  logic hitStatus; // Address selects serial_port_status
  logic hitData;   // Address selects serial_data_register
  logic hitEvt;    // Address selects event status
  logic hitMask;   // Address selects event mask
  logic wrStatus;  // Write to serial_port_status
  logic wrData;    // Write to serial_data_register
  logic wrEvt;     // Write to event status
  logic wrMask;    // Write to event mask

  assign hitStatus = (busReq.addr == spi_status_pkg::STATUS_ADDR);
  assign hitData   = (busReq.addr == spi_status_pkg::DATA_ADDR);
  assign hitEvt    = (busReq.addr == spi_status_pkg::EVT_ADDR);
  assign hitMask   = (busReq.addr == spi_status_pkg::MASK_ADDR);
  assign wrStatus  = busReq.wr & hitStatus;
  assign wrData    = busReq.wr & hitData;
  assign wrEvt     = busReq.wr & hitEvt;
  assign wrMask    = busReq.wr & hitMask;

  // Slave-select synchroniser

  logic selSync_n; // Synchronised active-low slave select

  // Pin is asynchronous, two flops before any use
  bit_sync #(
    .RST_VAL (spi_status_pkg::SEL_IDLE)
  ) u_sel_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (slaveSelectPin_n),
    .syncOut  (selSync_n)
  );

  // Flag set and clear terms

  logic doneSet;  // End of transfer
  logic doneClr;  // Vectoring or zero write
  logic wcolSet;  // Data write while shifter busy
  logic wcolClr;  // Zero write or data write while idle
  logic modeOk;   // Master mode with detection enabled
  logic modfSet;  // Select held low under modeOk
  logic modfClr;  // Zero write to fault bit

  assign doneSet = shiftInd.xferDone;
  assign doneClr = vectorAck
                 | (wrStatus & ~busReq.wdata[spi_status_pkg::DONE_BIT]);
  assign wcolSet = wrData & shiftInd.busy;
  assign wcolClr = (wrStatus & ~busReq.wdata[spi_status_pkg::WRITE_COLLISION_FLAG_BIT])
                 | (wrData & ~shiftInd.busy);
  assign modeOk  = shiftInd.masterMode & ~shiftInd.selDetDis;
  assign modfSet = modeOk & ~selSync_n;
  assign modfClr = wrStatus & ~busReq.wdata[spi_status_pkg::MODE_FAULT_FLAG_BIT];

  // The three status flags

  logic doneFlag; // transfer_done_flag
  logic wcolFlag; // write_collision_flag
  logic modfFlag; // mode_fault_flag

  // Transfer complete, set wins over a clear in the same cycle
  sticky_flag u_done (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .setEv    (doneSet),
    .clrEv    (doneClr),
    .flag     (doneFlag)
  );

  // Write collision
  sticky_flag u_write_collision_flag (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .setEv    (wcolSet),
    .clrEv    (wcolClr),
    .flag     (wcolFlag)
  );

  // Mode fault; stays set while the select is still held low
  sticky_flag u_mode_fault_flag (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .setEv    (modfSet),
    .clrEv    (modfClr),
    .flag     (modfFlag)
  );

  logic [7:0] statusVal; // Read view of serial_port_status
  logic       anyFlag;   // Any status flag set

  assign statusVal = {doneFlag, wcolFlag, modfFlag, 5'h00};
  assign anyFlag   = doneFlag | wcolFlag | modfFlag;

  // Sticky events and mask

  logic       modfSetPrev_ff; // Last cycle's fault condition
  logic       modfEdge;       // Fault condition just appeared
  logic [7:0] evtSet;         // Event set vector
  logic [7:0] evtClr;         // Write-one-to-clear vector
  logic [7:0] evt_ff;         // Sticky event status
  logic [7:0] nxt_evt;        // Next event status
  logic [7:0] mask_ff;        // Event mask
  logic [7:0] nxt_mask;       // Next event mask

  assign modfEdge = modfSet & ~modfSetPrev_ff;
  assign evtSet   = {doneSet, wcolSet, modfEdge, 5'h00};
  assign evtClr   = wrEvt ? busReq.wdata : 8'h00;
  assign nxt_evt  = evtSet | (evt_ff & ~evtClr);
  assign nxt_mask = wrMask ? (busReq.wdata & 8'hE0) : mask_ff;

  // Event and mask storage; set beats a write-one clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      modfSetPrev_ff <= 1'b0;
      evt_ff         <= spi_status_pkg::EVT_RST;
      mask_ff        <= spi_status_pkg::MASK_RST;
    end else begin
      modfSetPrev_ff <= modfSet;
      evt_ff         <= nxt_evt;
      mask_ff        <= nxt_mask;
    end
  end

  // Read data

  logic [7:0] rdMux;       // Selected read value
  logic [7:0] nxt_rdata;   // Next read data
  logic [7:0] regRdata_ff; // Registered read data

  assign rdMux = hitStatus ? statusVal :
                 hitEvt    ? evt_ff    :
                 hitMask   ? mask_ff   : 8'h00;
  // Data only in the cycle after a read strobe, zero otherwise
  assign nxt_rdata = busReq.rd ? rdMux : spi_status_pkg::RDATA_RST;

  // Interrupt outputs

  logic spiIrq_ff;  // Peripheral request
  logic intrOut_ff; // Masked event interrupt
  logic evtPending; // Some unmasked event is set

  assign evtPending = |(evt_ff & mask_ff);

  // Output flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regRdata_ff <= spi_status_pkg::RDATA_RST;
      spiIrq_ff   <= 1'b0;
      intrOut_ff  <= 1'b0;
    end else begin
      regRdata_ff <= nxt_rdata;
      spiIrq_ff   <= anyFlag;
      intrOut_ff  <= evtPending;
    end
  end

  assign regRdata = regRdata_ff;
  assign spiIrq   = spiIrq_ff;
  assign intrOut  = intrOut_ff;

  // Assertions

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Pin held low three cycles while master with detection on
  sequence selLowHeld;
    (!slaveSelectPin_n && modeOk) [*3];
  endsequence

  // Zero write to the status register for a chosen bit
  sequence zeroWrite(int b);
    wrStatus && !busReq.wdata[b];
  endsequence

  // Data register write while the shifter is busy
  sequence busyWrite;
    wrData && shiftInd.busy;
  endsequence

  done_set_a: assert property (
    shiftInd.xferDone |=> doneFlag && statusVal[spi_status_pkg::DONE_BIT])
    else $error("done flag not set after transfer end");

  vector_clear_a: assert property (
    vectorAck && !shiftInd.xferDone |=> !doneFlag)
    else $error("done flag not cleared on vectoring");

  done_zero_a: assert property (
    zeroWrite(spi_status_pkg::DONE_BIT) and !shiftInd.xferDone |=> !doneFlag)
    else $error("done flag not cleared by zero write");

  write_collision_flag_set_a: assert property (
    busyWrite |=> wcolFlag ##1 (wcolFlag || $past(wcolClr)))
    else $error("collision flag not set by busy write");

  write_collision_flag_clear_a: assert property (
    (wrData && !shiftInd.busy) or (zeroWrite(spi_status_pkg::WRITE_COLLISION_FLAG_BIT) and !wcolSet) |=> !wcolFlag)
    else $error("collision flag not cleared");

  mode_fault_flag_set_a: assert property (
    selLowHeld |=> modfFlag)
    else $error("mode fault not set on select low");

  mode_fault_flag_clear_a: assert property (
    zeroWrite(spi_status_pkg::MODE_FAULT_FLAG_BIT) and !modfSet |=> !modfFlag)
    else $error("mode fault not cleared by zero write");

  irq_level_a: assert property (
    ##1 (spiIrq == $past(anyFlag)))
    else $error("interrupt request does not follow flags");

  intr_mask_a: assert property (
    ##1 (intrOut == $past(evtPending)))
    else $error("masked interrupt does not follow events");

  read_data_a: assert property (
    busReq.rd && hitStatus |=> regRdata == $past(statusVal))
    else $error("status read data wrong");

  // Flags move only on their own set and clear terms; set terms also record sticky events
  done_hold_a: assert property (
    !doneFlag && !shiftInd.xferDone |=> !doneFlag)
    else $error("done flag set without a transfer end");

  done_keep_a: assert property (
    doneFlag && !vectorAck && !wrStatus |=> doneFlag)
    else $error("done flag lost without a clear");

  write_collision_flag_hold_a: assert property (
    !wcolFlag && !(wrData && shiftInd.busy) |=> !wcolFlag)
    else $error("collision flag set without a busy write");

  write_collision_flag_event_a: assert property (
    busyWrite |=> evt_ff[spi_status_pkg::WRITE_COLLISION_FLAG_BIT])
    else $error("collision event not recorded");

  mode_fault_flag_keep_a: assert property (
    modfSet |=> modfFlag)
    else $error("mode fault cleared while condition holds");

  mode_fault_flag_hold_a: assert property (
    !modfFlag && !modfSet |=> !modfFlag)
    else $error("mode fault set without its condition");

  mode_fault_flag_event_a: assert property (
    $rose(modfSet) |=> evt_ff[spi_status_pkg::MODE_FAULT_FLAG_BIT])
    else $error("mode fault event not recorded");

  evt_done_a: assert property (
    shiftInd.xferDone |=> evt_ff[spi_status_pkg::DONE_BIT])
    else $error("transfer end event not recorded");

  // Sticky event clear, mask write and read views
  evt_clear_a: assert property (
    wrEvt && busReq.wdata[spi_status_pkg::DONE_BIT] && !shiftInd.xferDone |=> !evt_ff[spi_status_pkg::DONE_BIT])
    else $error("event bit not cleared by a one write");

  mask_write_a: assert property (
    wrMask |=> mask_ff == ($past(busReq.wdata) & 8'hE0))
    else $error("mask write not stored");

  idle_read_a: assert property (
    !busReq.rd |=> regRdata == spi_status_pkg::RDATA_RST)
    else $error("read data not idle without a read");

  evt_read_a: assert property (
    busReq.rd && hitEvt |=> regRdata == $past(evt_ff))
    else $error("event read data wrong");

  mask_read_a: assert property (
    busReq.rd && hitMask |=> regRdata == $past(mask_ff))
    else $error("mask read data wrong");

  data_read_a: assert property (
    busReq.rd && hitData |=> regRdata == 8'h00)
    else $error("data register read not zero");

endmodule

/* File: src/spi_status_pkg.sv */
/*
  Shared constants and carrier types for the serial port status flag block.
  Assumes an 8-bit special-function-register space and a single core clock.
*/
package spi_status_pkg;

  // Register offsets in the special-function-register space
  localparam logic [7:0] STATUS_ADDR = 8'hBD; // serial_port_status
  localparam logic [7:0] DATA_ADDR   = 8'hBC; // serial_data_register (write seen only)
  localparam logic [7:0] EVT_ADDR    = 8'hBE; // Sticky event status, write one to clear
  localparam logic [7:0] MASK_ADDR   = 8'hBF; // Event interrupt mask

  // Field positions, shared by status, event and mask registers
  localparam int DONE_BIT = 7; // transfer_done_flag
  localparam int WRITE_COLLISION_FLAG_BIT = 6; // write_collision_flag
  localparam int MODE_FAULT_FLAG_BIT = 5; // mode_fault_flag

  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] EVT_RST    = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] RDATA_RST  = 8'h00;

  // Idle level of the active-low slave-select pin
  localparam logic SEL_IDLE = 1'b1;

  // Register bus request from the core
  typedef struct packed {
    logic [7:0] addr;  // Register address
    logic [7:0] wdata; // Write data
    logic       wr;    // Write strobe, one cycle
    logic       rd;    // Read strobe, one cycle
  } bus_req_t;

  // Indications from the shift engine and control register
  typedef struct packed {
    logic xferDone;   // One-cycle pulse at end of a transfer
    logic busy;       // shifter_busy_flag level
    logic masterMode; // Master mode selected
    logic selDetDis;  // select_detect_disable level
  } shift_ind_t;

endpackage

/* File: src/bit_sync.sv */
/*
  Two-stage synchroniser for an asynchronous level.
  Assumes a synchronous active-low reset on the same clock.
*/
`timescale 1ns/1ns
module bit_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic meta_ff; // First stage, read only by the second stage
  logic sync_ff; // Second stage, safe to use

  // Shift the level through two flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;
endmodule

/* File: src/sticky_flag.sv */
/*
  One hardware-set, clearable flag; a set in the cycle of a clear wins.
  Assumes set and clear are single-clock-domain terms.
*/
`timescale 1ns/1ns
module sticky_flag (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic setEv,
  input  wire logic clrEv,
  output logic      flag
);
  logic flag_ff;  // Stored flag
  logic nxt_flag; // Next value

  // Set has priority over clear
  assign nxt_flag = setEv | (flag_ff & ~clrEv);

  // Flag storage, zero after reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;
endmodule

/* File: testbench/spi_shift_model.sv */
/*
  Behavioural shift engine: busy for a fixed span after a start, then an end pulse.
  Assumes start pulses and mode levels come from the bench on core_clk.
*/
`timescale 1ns/1ns
module spi_shift_model #(
  parameter int XFER_LEN = 8
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  startXfer,
  input  wire logic                  masterMode,
  input  wire logic                  selDetDis,
  output spi_status_pkg::shift_ind_t shiftInd
);
  logic [7:0] cnt_ff;  // Shift cycles left
  logic       done_ff; // End-of-transfer pulse

  // Count a transfer down and pulse once as it ends
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff  <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (cnt_ff == 8'h01);
      if (startXfer) begin
        cnt_ff <= XFER_LEN[7:0];
      end else if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end

  // Busy covers the whole count
  assign shiftInd = '{xferDone: done_ff, busy: (cnt_ff != 8'h00), masterMode: masterMode, selDetDis: selDetDis};
endmodule

/* File: testbench/spi_status_flags_test.sv */
/*
  Self-checking bench for the serial port status flags.
  Assumes the shift engine model beside it and a 50 MHz core clock.
*/
`timescale 1ns/1ns
module spi_status_flags_test;
  logic                       core_clk = 1'b0; // Core clock
  logic                       rst_n    = 1'b0; // Reset, active low
  spi_status_pkg::bus_req_t   req      = '0;   // Register bus request
  spi_status_pkg::shift_ind_t shiftInd;        // Shift engine indications
  logic                       start    = 1'b0; // Transfer start pulse
  logic                       mm       = 1'b0; // Master mode level
  logic                       sdis     = 1'b1; // Select detect disable
  logic                       vecAck   = 1'b0; // Interrupt vectoring pulse
  logic                       ssPin_n  = 1'b1; // Slave-select pin
  logic [7:0]                 regRdata;        // Read data
  logic                       spiIrq;          // Flag interrupt
  logic                       intrOut;         // Masked event interrupt
  int                         failures = 0;    // Mismatches
  int                         checked  = 0;    // Comparisons

  spi_shift_model i_shift (.core_clk, .rst_n, .startXfer(start), .masterMode(mm), .selDetDis(sdis), .shiftInd);
  spi_status_flags i_dut (.core_clk, .rst_n, .busReq(req), .shiftInd, .vectorAck(vecAck),
                          .slaveSelectPin_n(ssPin_n), .regRdata, .spiIrq, .intrOut);

  // Clock generator
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // Compare one byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask

  // One-cycle register read, data judged in the following cycle, idle zero after it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    @(negedge core_clk);
    chk(regRdata, exp);
    @(negedge core_clk);
    chk(regRdata, spi_status_pkg::RDATA_RST);
  endtask

  // Launch a transfer in the model
  task automatic startX();
    @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
  endtask

  // Wait, bounded, until the shifter goes idle
  task automatic waitIdle();
    @(negedge core_clk);
    for (int n = 0; n < 40 && shiftInd.busy !== 1'b0; n++) @(negedge core_clk);
  endtask

  // Reset values and idle interrupt
  task automatic t_reset();
    rd(spi_status_pkg::STATUS_ADDR, 8'h00);
    rd(spi_status_pkg::EVT_ADDR, 8'h00);
    rd(spi_status_pkg::MASK_ADDR, 8'h00);
    chk({7'h00, spiIrq}, 8'h00);
  endtask

  // Transfer end sets done; zero write clears it, ones elsewhere do nothing
  task automatic t_done();
    startX();
    waitIdle();
    rd(spi_status_pkg::STATUS_ADDR, 8'h80);
    chk({7'h00, spiIrq}, 8'h01);
    wr(spi_status_pkg::STATUS_ADDR, 8'h7F);
    rd(spi_status_pkg::STATUS_ADDR, 8'h00);
    chk({7'h00, spiIrq}, 8'h00);
  endtask

  // Vectoring clears done
  task automatic t_vector();
    startX();
    waitIdle();
    rd(spi_status_pkg::STATUS_ADDR, 8'h80);
    @(posedge core_clk);
    vecAck <= 1'b1;
    @(posedge core_clk);
    vecAck <= 1'b0;
    rd(spi_status_pkg::STATUS_ADDR, 8'h00);
  endtask

  // Data write while busy collides; idle rewrite or zero write clears
  task automatic t_coll();
    startX();
    wr(spi_status_pkg::DATA_ADDR, 8'h55);
    rd(spi_status_pkg::STATUS_ADDR, 8'h40);
    waitIdle();
    rd(spi_status_pkg::STATUS_ADDR, 8'hC0);
    wr(spi_status_pkg::DATA_ADDR, 8'hAA);
    rd(spi_status_pkg::STATUS_ADDR, 8'h80);
    startX();
    wr(spi_status_pkg::DATA_ADDR, 8'h5A);
    waitIdle();
    wr(spi_status_pkg::STATUS_ADDR, 8'hBF);
    rd(spi_status_pkg::STATUS_ADDR, 8'h80);
    wr(spi_status_pkg::STATUS_ADDR, 8'h00);
  endtask

  // Select low in master mode with detect enabled raises the fault
  task automatic t_fault();
    mm <= 1'b1;
    ssPin_n <= 1'b0;
    rd(spi_status_pkg::STATUS_ADDR, 8'h00);
    @(posedge core_clk);
    sdis <= 1'b0;
    rd(spi_status_pkg::STATUS_ADDR, 8'h20);
    chk({7'h00, spiIrq}, 8'h01);
    wr(spi_status_pkg::STATUS_ADDR, 8'h00);
    rd(spi_status_pkg::STATUS_ADDR, 8'h20);
    @(posedge core_clk);
    ssPin_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(spi_status_pkg::STATUS_ADDR, 8'hDF);
    rd(spi_status_pkg::STATUS_ADDR, 8'h00);
    @(posedge core_clk);
    mm <= 1'b0;
    ssPin_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(spi_status_pkg::STATUS_ADDR, 8'h00);
    @(posedge core_clk);
    ssPin_n <= 1'b1;
  endtask

  // Sticky events, mask and masked interrupt, unmapped read
  task automatic t_intr();
    rd(spi_status_pkg::EVT_ADDR, 8'hE0);
    chk({7'h00, intrOut}, 8'h00);
    wr(spi_status_pkg::MASK_ADDR, 8'hFF);
    rd(spi_status_pkg::MASK_ADDR, 8'hE0);
    chk({7'h00, intrOut}, 8'h01);
    wr(spi_status_pkg::EVT_ADDR, 8'h80);
    rd(spi_status_pkg::EVT_ADDR, 8'h60);
    wr(spi_status_pkg::EVT_ADDR, 8'h60);
    rd(spi_status_pkg::EVT_ADDR, 8'h00);
    chk({7'h00, intrOut}, 8'h00);
    wr(spi_status_pkg::MASK_ADDR, 8'h00);
    rd(8'h10, 8'h00);
  endtask

  // Print counts and verdict, then stop
  task automatic end_sim();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_done();
    t_vector();
    t_coll();
    t_fault();
    t_intr();
    end_sim();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule
